/* File: verilog/supply_status_pkg.sv */
package supply_status_pkg;

    // Command codes of the status and reading registers
    localparam logic [7:0] CMD_VOLT_STATUS   = 8'h7a;
    localparam logic [7:0] CMD_TEMP_STATUS   = 8'h7d;
    localparam logic [7:0] CMD_COMMS_STATUS  = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_VOLT_READING  = 8'h8b;

    // Page that selects the device-wide vendor layout
    localparam logic [7:0] PAGE_GLOBAL = 8'hff;

    // Rail voltage status bit positions
    localparam int VOLT_OV_FAULT_BIT  = 7;
    localparam int VOLT_OV_WARN_BIT   = 6;
    localparam int VOLT_UV_WARN_BIT   = 5;
    localparam int VOLT_UV_FAULT_BIT  = 4;
    localparam int VOLT_TIMEOUT_BIT   = 2;

    // Temperature status bit positions
    localparam int TEMP_FAULT_BIT     = 7;
    localparam int TEMP_WARN_BIT      = 6;

    // Communication status bit positions
    localparam int COMM_BAD_CMD_BIT   = 7;
    localparam int COMM_BAD_DATA_BIT  = 6;
    localparam int COMM_LOG_FULL_BIT  = 0;

    // Per-rail vendor status bit positions
    localparam int RAIL_SEQ_DOWN_BIT  = 7;
    localparam int RAIL_MARGIN_BIT    = 3;
    localparam int RAIL_LOST_BIT      = 2;

    // Device-wide vendor status bit positions
    localparam int GLB_LOCK_BIT       = 7;
    localparam int GLB_SHUTDOWN_BIT   = 6;
    localparam int GLB_WATCHDOG_BIT   = 4;
    localparam int GLB_CONTROL_BIT    = 3;

    // Values after reset
    localparam logic [15:0] READING_RESET = 16'h0000;
    localparam logic        LOST_RESET    = 1'b1;
    localparam logic        PIN_IDLE      = 1'b1;

    // Rail count and reading refresh period
    localparam int MAX_RAILS       = 16;
    localparam int REFRESH_MS      = 5;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int REFRESH_CYCLES  = (REFRESH_MS * 1000000) / CLK_PERIOD_NS;

endpackage

/* File: verilog/supply_status_bank.sv */
// Overview of operation
// - Voltage status: overvolt fault b7, warn b6, undervolt warn b5, fault b4, timeout b2.
// - Unassigned bits of every status byte always read zero.
// - Temperature status byte: overtemp fault b7, overtemp warning b6, both latched.
// - Cleared temperature bit sets again at once while its condition persists.
// - Communication status bit 7 latches on an invalid or unsupported command.
// - Communication status bit 6 latches on invalid or unsupported data.
// - Cleared bad-command and bad-data flags return only on a new event.
// - Communication bit 0 shows live whether the event log is full.
// - With log wrap on, log-full clears once the log is overwritten.
// - Voltage reading is measured value, two bytes, refreshed every 5 ms.
// - Vendor status layout follows page: 0-15 per rail, 255 device-wide.
// - Per-rail bit 7 live-set while sequencer holds supply enable off.
// - Sequenced-down reads zero for disabled rail; follows sequencer, not pin.
// - Per-rail bit 3 latches when closed-loop margining fails.
// - Supply-lost starts set after reset until rail first exceeds good-rise.
// - Sequenced-down and supply-lost never raise the alert by themselves.
// - Page 255 bit 7 shows lock live and never raises the alert.
// - Page 255 bit 6 latches on each low pulse of the shutdown input.
// - Page 255 bit 4 latches at reset when watchdog caused the reset.
// - Page 255 bit 3 latches on control deassert when the pin is in use.
// - Voltage bits latched; re-set if condition persists, timeout only on recurrence.
// - Negative turn-on limit marks rail unsequenced and mutes its voltage faults.
`timescale 1ns/1ns
module supply_status_bank #(
    parameter int NUM_RAILS      = supply_status_pkg::MAX_RAILS,
    parameter int REFRESH_PERIOD = supply_status_pkg::REFRESH_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    // Status read port from the command engine
    input  wire logic                  rd_req,
    input  wire logic [7:0]            rd_cmd,
    input  wire logic [7:0]            rd_page,
    output logic                       rd_valid,
    output logic [15:0]                rd_data,
    input  wire logic                  clear_faults,
    input  wire logic                  bad_cmd_event,
    input  wire logic                  bad_data_event,
    // Rail voltage monitor
    input  wire logic [NUM_RAILS-1:0]  ov_fault_cond,
    input  wire logic [NUM_RAILS-1:0]  ov_warn_cond,
    input  wire logic [NUM_RAILS-1:0]  uv_warn_cond,
    input  wire logic [NUM_RAILS-1:0]  uv_fault_cond,
    input  wire logic [NUM_RAILS-1:0]  startup_timeout_event,
    input  wire logic [NUM_RAILS-1:0]  turn_on_limit_negative,
    input  wire logic [NUM_RAILS-1:0]  above_good_rise,
    input  wire logic [NUM_RAILS-1:0]  below_good_fall,
    // Sequencer and margining
    input  wire logic [NUM_RAILS-1:0]  seq_enable_on,
    input  wire logic [NUM_RAILS-1:0]  margin_fail_event,
    input  wire logic                  good_force_test,
    input  wire logic [NUM_RAILS-1:0]  good_force_lost,
    // Voltage measurement
    output logic                       meas_start,
    input  wire logic                  meas_done,
    input  wire logic [3:0]            meas_rail,
    input  wire logic [15:0]           meas_value,
    // Temperature
    input  wire logic                  overtemp_fault_cond,
    input  wire logic                  overtemp_warning_cond,
    // Event log
    input  wire logic                  log_full,
    input  wire logic                  log_wrap_enable,
    input  wire logic                  log_overwrite_event,
    // Device-wide inputs
    input  wire logic                  lock_active,
    input  wire logic                  shutdown_n,
    input  wire logic                  watchdog_reset_cause,
    input  wire logic                  control_active,
    input  wire logic                  onoff_uses_pin,
    // Host alert request
    output logic                       alert_event
);
    import supply_status_pkg::*;

    localparam int CW = $clog2(REFRESH_PERIOD + 1);

    initial begin
        if (NUM_RAILS < 1 || NUM_RAILS > MAX_RAILS)
            $error("NUM_RAILS must be 1 to 16");
        if (REFRESH_PERIOD < 2)
            $error("REFRESH_PERIOD must be at least 2");
    end

    // Voltage status kept as five packed flags: ovf, ovw, uvw, uvf, timeout
    typedef struct packed {
        logic [NUM_RAILS-1:0][4:0]  vstat;
        logic [NUM_RAILS-1:0]       margin;
        logic [NUM_RAILS-1:0]       lost;
        logic                       overtemp_fault;
        logic                       overtemp_warning;
        logic                       bad_cmd;
        logic                       bad_data;
        logic                       log_overwritten;
        logic                       shut_ev;
        logic                       wdog;
        logic                       ctrl_ev;
        logic                       started;
        logic                       shut_prev;
        logic                       ctrl_prev;
        logic [CW-1:0]              tick_cnt;
        logic                       tick;
        logic                       rd_valid;
        logic [15:0]                rd_data;
        logic                       alert;
        logic [NUM_RAILS-1:0][15:0] reading;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    logic [7:0] volt_byte;
    logic [7:0] temp_byte;
    logic [7:0] comm_byte;
    logic [7:0] rail_byte;
    logic [7:0] glb_byte;
    logic       page_rail;
    logic       log_full_flag;
    logic [3:0] rail_idx;

    assign rail_idx  = rd_page[3:0];
    assign page_rail = (rd_page < 8'(NUM_RAILS));

    // Wrap mode: entries are freed ahead of each overwrite, so full drops
    assign log_full_flag = log_full & ~(log_wrap_enable & state_ff.log_overwritten);

    always_comb begin
        volt_byte = 8'h00;
        temp_byte = 8'h00;
        comm_byte = 8'h00;
        rail_byte = 8'h00;
        glb_byte  = 8'h00;
        if (page_rail) begin
            volt_byte[VOLT_OV_FAULT_BIT] = state_ff.vstat[rail_idx][4];
            volt_byte[VOLT_OV_WARN_BIT]  = state_ff.vstat[rail_idx][3];
            volt_byte[VOLT_UV_WARN_BIT]  = state_ff.vstat[rail_idx][2];
            volt_byte[VOLT_UV_FAULT_BIT] = state_ff.vstat[rail_idx][1];
            volt_byte[VOLT_TIMEOUT_BIT]  = state_ff.vstat[rail_idx][0];
            // Sequencer state, not the pin; disabled rails read zero
            rail_byte[RAIL_SEQ_DOWN_BIT] = ~turn_on_limit_negative[rail_idx]
                                         & ~seq_enable_on[rail_idx];
            rail_byte[RAIL_MARGIN_BIT]   = state_ff.margin[rail_idx];
            rail_byte[RAIL_LOST_BIT]     = good_force_test ? good_force_lost[rail_idx]
                                         : state_ff.lost[rail_idx];
        end
        temp_byte[TEMP_FAULT_BIT]    = state_ff.overtemp_fault;
        temp_byte[TEMP_WARN_BIT]     = state_ff.overtemp_warning;
        comm_byte[COMM_BAD_CMD_BIT]  = state_ff.bad_cmd;
        comm_byte[COMM_BAD_DATA_BIT] = state_ff.bad_data;
        comm_byte[COMM_LOG_FULL_BIT] = log_full_flag;
        glb_byte[GLB_LOCK_BIT]       = lock_active;
        glb_byte[GLB_SHUTDOWN_BIT]   = state_ff.shut_ev;
        glb_byte[GLB_WATCHDOG_BIT]   = state_ff.wdog;
        glb_byte[GLB_CONTROL_BIT]    = state_ff.ctrl_ev;
    end

    always_comb begin
        logic [4:0] vset;
        logic       new_set;
        logic       bad_page;
        logic       bad_code;
        vset      = 5'h00;
        new_set   = 1'b0;
        bad_page  = 1'b0;
        bad_code  = 1'b0;
        nxt_state = state_ff;

        // Rail flags; set wins over clear so no event is lost
        for (int i = 0; i < NUM_RAILS; i++) begin
            // Unsequenced rail: voltage monitoring muted
            vset = {ov_fault_cond[i], ov_warn_cond[i], uv_warn_cond[i],
                    uv_fault_cond[i], startup_timeout_event[i]}
                 & {5{~turn_on_limit_negative[i]}};
            // Level conditions re-set while present, timeout only as event
            nxt_state.vstat[i] = (clear_faults ? 5'h00 : state_ff.vstat[i]) | vset;
            new_set = new_set | (|(vset & ~state_ff.vstat[i]));
            nxt_state.margin[i] = (clear_faults ? 1'b0 : state_ff.margin[i])
                                | margin_fail_event[i];
            new_set = new_set | (margin_fail_event[i] & ~state_ff.margin[i]);
            // Starts set; clears on first rise, sets again on a fall
            if (state_ff.lost[i] && above_good_rise[i])
                nxt_state.lost[i] = 1'b0;
            else if (!state_ff.lost[i] && below_good_fall[i])
                nxt_state.lost[i] = 1'b1;
        end

        nxt_state.overtemp_fault = (clear_faults ? 1'b0 : state_ff.overtemp_fault)
                           | overtemp_fault_cond;
        nxt_state.overtemp_warning  = (clear_faults ? 1'b0 : state_ff.overtemp_warning)
                           | overtemp_warning_cond;
        new_set = new_set | (overtemp_fault_cond & ~state_ff.overtemp_fault)
                          | (overtemp_warning_cond & ~state_ff.overtemp_warning);

        // Log overwrite tracking; any cycle with the log not full resets it
        if (!log_full)
            nxt_state.log_overwritten = 1'b0;
        else if (log_overwrite_event)
            nxt_state.log_overwritten = 1'b1;

        // Edge-caught device-wide events
        nxt_state.shut_prev = shutdown_n;
        nxt_state.ctrl_prev = control_active;
        // Latches regardless of whether the shutdown pin is honoured
        nxt_state.shut_ev = (clear_faults ? 1'b0 : state_ff.shut_ev)
                          | (state_ff.shut_prev & ~shutdown_n);
        nxt_state.ctrl_ev = (clear_faults ? 1'b0 : state_ff.ctrl_ev)
                          | (onoff_uses_pin & state_ff.ctrl_prev & ~control_active);
        new_set = new_set | (state_ff.shut_prev & ~shutdown_n & ~state_ff.shut_ev)
                          | (onoff_uses_pin & state_ff.ctrl_prev & ~control_active
                             & ~state_ff.ctrl_ev);
        // Reset cause is sampled once, on the first enabled edge after release
        nxt_state.started = 1'b1;
        nxt_state.wdog = (clear_faults ? 1'b0 : state_ff.wdog)
                       | (~state_ff.started & watchdog_reset_cause);
        new_set = new_set | (~state_ff.started & watchdog_reset_cause);

        // Reading refresh tick
        nxt_state.tick = 1'b0;
        if (state_ff.tick_cnt == CW'(REFRESH_PERIOD - 1)) begin
            nxt_state.tick_cnt = '0;
            nxt_state.tick     = 1'b1;
        end else begin
            nxt_state.tick_cnt = state_ff.tick_cnt + CW'(1);
        end
        // Extra bit so a full 16-rail count is not cut to zero
        if (meas_done && ({1'b0, meas_rail} < 5'(NUM_RAILS)))
            nxt_state.reading[meas_rail] = meas_value;

        // Read port; a read clears no flag, but a bad code or page sets bad_cmd or bad_data
        nxt_state.rd_valid = 1'b0;
        if (rd_req) begin
            nxt_state.rd_valid = 1'b1;
            nxt_state.rd_data  = 16'h0000;
            case (rd_cmd)
                CMD_VOLT_STATUS: begin
                    bad_page = ~page_rail;
                    nxt_state.rd_data = {8'h00, volt_byte};
                end
                CMD_TEMP_STATUS: begin
                    nxt_state.rd_data = {8'h00, temp_byte};
                end
                CMD_COMMS_STATUS: begin
                    nxt_state.rd_data = {8'h00, comm_byte};
                end
                CMD_VENDOR_STATUS: begin
                    // Layout picked by page; host must set it first
                    if (rd_page == PAGE_GLOBAL)
                        nxt_state.rd_data = {8'h00, glb_byte};
                    else
                        nxt_state.rd_data = {8'h00, rail_byte};
                    bad_page = ~page_rail & (rd_page != PAGE_GLOBAL);
                end
                CMD_VOLT_READING: begin
                    bad_page = ~page_rail;
                    if (page_rail)
                        nxt_state.rd_data = state_ff.reading[rail_idx];
                end
                default: begin
                    bad_code = 1'b1;
                end
            endcase
        end

        // Only new events re-latch these after a clear
        // A bad code in the cycle of a clear still latches; set wins
        nxt_state.bad_cmd  = (clear_faults ? 1'b0 : state_ff.bad_cmd)
                           | bad_cmd_event | (rd_req & bad_code);
        nxt_state.bad_data = (clear_faults ? 1'b0 : state_ff.bad_data)
                           | bad_data_event | (rd_req & bad_page);
        new_set = new_set | (nxt_state.bad_cmd & ~state_ff.bad_cmd)
                          | (nxt_state.bad_data & ~state_ff.bad_data);

        // Lost, sequenced-down and lock are not alert sources
        nxt_state.alert = new_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff           <= '0;
            state_ff.lost      <= {NUM_RAILS{LOST_RESET}};
            state_ff.shut_prev <= PIN_IDLE;
            state_ff.ctrl_prev <= PIN_IDLE;
            state_ff.reading   <= {NUM_RAILS{READING_RESET}};
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign rd_valid    = state_ff.rd_valid;
    assign rd_data     = state_ff.rd_data;
    assign meas_start  = state_ff.tick;
    assign alert_event = state_ff.alert;

endmodule

/* File: testbench/supply_status_bank_assertions.sv */
`timescale 1ns/1ns
module supply_status_bank_checker #(
    parameter int NUM_RAILS      = 16,
    parameter int REFRESH_PERIOD = 8
) (
    // Clock and reset
    input logic                 clk,
    input logic                 rst_n,
    // Read port
    input logic                 rd_req,
    input logic [7:0]           rd_cmd,
    input logic [7:0]           rd_page,
    input logic                 rd_valid,
    input logic [15:0]          rd_data,
    input logic                 meas_start,
    // Status sources
    input logic                 overtemp_warning_cond,
    input logic                 log_full,
    input logic                 log_wrap_enable,
    input logic                 good_force_test,
    input logic                 lock_active,
    input logic [NUM_RAILS-1:0] turn_on_limit_negative,
    input logic [NUM_RAILS-1:0] seq_enable_on,
    input logic [NUM_RAILS-1:0] good_force_lost
);
    import supply_status_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Live view of the addressed rail; only up to 16 rails
    wire seq_down = !turn_on_limit_negative[rd_page[3:0]] && !seq_enable_on[rd_page[3:0]];
    wire forced   = good_force_lost[rd_page[3:0]];
    // Cycles since the last start; holds for any period value
    int since_meas;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            since_meas <= 0;
        else
            since_meas <= meas_start ? 1 : since_meas + 1;
    end
    a_read_answer: assert property (rd_valid == $past(rd_req))
        else $error("read answer not one cycle after request");
    a_data_holds: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data changed without a read");
    a_volt_zero: assert property (rd_valid && $past(rd_cmd) == CMD_VOLT_STATUS
        |-> (rd_data & 16'hff0b) == 16'h0000) else $error("voltage status spare bit set");
    a_temp_zero: assert property (rd_valid && $past(rd_cmd) == CMD_TEMP_STATUS
        |-> (rd_data & 16'hff3f) == 16'h0000) else $error("temperature spare bit set");
    a_temp_reset: assert property (rd_valid && $past(rd_cmd) == CMD_TEMP_STATUS
        && $past(overtemp_warning_cond, 2) |-> rd_data[6]) else $error("warning not re-set");
    a_comm_live: assert property (rd_valid && $past(rd_cmd) == CMD_COMMS_STATUS
        && !$past(log_wrap_enable) |-> (rd_data & 16'hff3e) == 16'h0000
        && rd_data[0] == $past(log_full)) else $error("comms status wrong");
    a_meas_period: assert property (since_meas != 0 |-> since_meas <= REFRESH_PERIOD
        && meas_start == (since_meas == REFRESH_PERIOD))
        else $error("measurement start period wrong");
    a_seq_down: assert property (rd_valid && $past(rd_cmd) == CMD_VENDOR_STATUS
        && $past(rd_page) < NUM_RAILS |-> rd_data[7] == $past(seq_down))
        else $error("sequenced-down bit wrong");
    a_force_lost: assert property (rd_valid && $past(rd_cmd) == CMD_VENDOR_STATUS
        && $past(rd_page) < NUM_RAILS && $past(good_force_test)
        |-> rd_data[2] == $past(forced)) else $error("forced lost bit wrong");
    a_lock_live: assert property (rd_valid && $past(rd_cmd) == CMD_VENDOR_STATUS
        && $past(rd_page) == PAGE_GLOBAL |-> rd_data[7] == $past(lock_active)
        && (rd_data & 16'hff27) == 16'h0000) else $error("device-wide layout wrong");
    c_flag_read: cover property (rd_valid && rd_data[7]);
    c_meas: cover property (meas_start);
    c_reading: cover property (rd_valid && $past(rd_cmd) == CMD_VOLT_READING);
endmodule
bind supply_status_bank supply_status_bank_checker #(.NUM_RAILS(NUM_RAILS),
    .REFRESH_PERIOD(REFRESH_PERIOD)) checker_i (.*);

/* File: testbench/host_read_model.sv */
`timescale 1ns/1ns
module host_read_model (
    // Clock and read orders from the bench
    input  logic       clk,
    input  logic       go,
    input  logic [7:0] cmd,
    input  logic [7:0] page,
    // Read port of the status bank
    output logic       rd_req,
    output logic [7:0] rd_cmd,
    output logic [7:0] rd_page
);
    initial {rd_req, rd_cmd, rd_page} = '0;
    // Page is set with or before its read, never after
    // Orders are taken on the edge, so the bench may change them just after it
    always @(posedge clk) begin
        rd_page <= page;
        rd_req  <= go;
        rd_cmd  <= go ? cmd : ~rd_cmd;
    end
endmodule

/* File: testbench/test_supply_status_bank.sv */
`timescale 1ns/1ns
module test_supply_status_bank;
    import supply_status_pkg::*;
    logic clk, rst_n, ce, rd_req, rd_valid, clear_faults, bad_cmd_event, bad_data_event, go;
    logic meas_start, meas_done, good_force_test, overtemp_fault_cond, overtemp_warning_cond;
    logic log_full, log_wrap_enable, log_overwrite_event, lock_active, shutdown_n;
    logic watchdog_reset_cause, control_active, onoff_uses_pin, alert_event;
    logic [3:0]  meas_rail;
    logic [7:0]  rd_cmd, rd_page, cmd, page;
    logic [15:0] rd_data, meas_value, ov_fault_cond, ov_warn_cond, uv_warn_cond, uv_fault_cond;
    logic [15:0] startup_timeout_event, turn_on_limit_negative, above_good_rise, below_good_fall;
    logic [15:0] seq_enable_on, margin_fail_event, good_force_lost, seed;
    logic [31:0] exp_q[$];
    int          failures, samples_checked, alerts, r, n;
    supply_status_bank #(.REFRESH_PERIOD(8)) DUT (.*);
    host_read_model partner (.*);
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic step(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = ~s;
        step();
        s = ~s;
    endtask
    task automatic rd(logic [7:0] c, logic [7:0] p, logic [15:0] e, logic [15:0] m = 16'hffff);
        cmd = c;
        page = p;
        go = 1'b1;
        exp_q.push_back({m, e});
        step();
        go = 1'b0;
        step(3);
    endtask
    task automatic chk(logic [15:0] got, logic [31:0] note);
        samples_checked++;
        if ((got & note[31:16]) !== note[15:0]) begin
            failures++;
            $display("mismatch at %0t: read %h expected %h", $time, got, note[15:0]);
        end
    endtask
    task automatic chk_alert(int e);
        samples_checked++;
        if (alerts != e) begin
            failures++;
            $display("mismatch at %0t: %0d alert pulses, expected %0d", $time, alerts, e);
        end
    endtask
    task automatic test_done();
        if (exp_q.size() != 0) begin
            failures++;
            $display("mismatch at %0t: %0d reads never answered", $time, exp_q.size());
        end
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (alert_event === 1'b1) alerts++;
        if (rd_valid === 1'b1) chk(rd_data, exp_q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        {rst_n, clear_faults, bad_cmd_event, bad_data_event, meas_done, good_force_test} = '0;
        {overtemp_fault_cond, overtemp_warning_cond, log_full, log_wrap_enable, go} = '0;
        {log_overwrite_event, lock_active, watchdog_reset_cause, meas_rail, cmd, page} = '0;
        {ov_fault_cond, ov_warn_cond, uv_warn_cond, uv_fault_cond, startup_timeout_event} = '0;
        {turn_on_limit_negative, above_good_rise, below_good_fall, seq_enable_on} = '0;
        {margin_fail_event, good_force_lost, meas_value} = '0;
        {ce, shutdown_n, control_active, onoff_uses_pin} = '1;
        seed = 16'h001f;
        step(5);
        rst_n = 1'b1;
        rd(CMD_VOLT_STATUS, 8'd3, 16'h0000);
        rd(CMD_VENDOR_STATUS, 8'd3, 16'h0084);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            r = int'(seed[3:0]);
            {ov_fault_cond[r], ov_warn_cond[r], uv_warn_cond[r], uv_fault_cond[r]} = seed[7:4];
            startup_timeout_event[r] = seed[8];
            step();
            {ov_fault_cond, ov_warn_cond, uv_warn_cond, uv_fault_cond} = '0;
            startup_timeout_event = '0;
            rd(CMD_VOLT_STATUS, 8'(r), {8'h00, seed[7:4], 1'b0, seed[8], 2'b00});
            pulse(clear_faults);
            rd(CMD_VOLT_STATUS, 8'(r), 16'h0000);
        end
        ov_warn_cond[5] = 1'b1;
        pulse(clear_faults);
        rd(CMD_VOLT_STATUS, 8'd5, 16'h0040);
        turn_on_limit_negative[5] = 1'b1;
        pulse(clear_faults);
        ov_fault_cond[5] = 1'b1;
        rd(CMD_VOLT_STATUS, 8'd5, 16'h0000);
        rd(CMD_VENDOR_STATUS, 8'd5, 16'h0000, 16'h0080);
        {turn_on_limit_negative, ov_fault_cond, ov_warn_cond} = '0;
        pulse(overtemp_fault_cond);
        rd(CMD_TEMP_STATUS, 8'd0, 16'h0080);
        overtemp_warning_cond = 1'b1;
        pulse(clear_faults);
        rd(CMD_TEMP_STATUS, 8'd0, 16'h0040);
        overtemp_warning_cond = 1'b0;
        pulse(bad_cmd_event);
        rd(CMD_COMMS_STATUS, 8'd0, 16'h0080);
        pulse(bad_data_event);
        log_full = 1'b1;
        rd(CMD_COMMS_STATUS, 8'd0, 16'h00c1);
        pulse(clear_faults);
        rd(CMD_COMMS_STATUS, 8'd0, 16'h0001);
        log_wrap_enable = 1'b1;
        pulse(log_overwrite_event);
        rd(CMD_COMMS_STATUS, 8'd0, 16'h0000);
        {log_full, log_wrap_enable} = '0;
        rd(8'h55, 8'd0, 16'h0000);
        rd(CMD_VOLT_STATUS, PAGE_GLOBAL, 16'h0000);
        rd(CMD_COMMS_STATUS, 8'd0, 16'h00c0);
        seed = lfsr(seed);
        meas_rail = 4'd9;
        meas_value = seed;
        pulse(meas_done);
        meas_value = ~seed;
        rd(CMD_VOLT_READING, 8'd9, seed);
        {seq_enable_on[9], above_good_rise[9], lock_active} = 3'b111;
        rd(CMD_VENDOR_STATUS, 8'd9, 16'h0000);
        margin_fail_event[9] = 1'b1;
        step();
        {margin_fail_event[9], above_good_rise[9], below_good_fall[9]} = 3'b001;
        rd(CMD_VENDOR_STATUS, 8'd9, 16'h000c);
        good_force_test = 1'b1;
        rd(CMD_VENDOR_STATUS, 8'd9, 16'h0008);
        good_force_test = 1'b0;
        n = alerts;
        {above_good_rise[9], below_good_fall[9], lock_active} = 3'b100;
        step();
        {seq_enable_on[9], above_good_rise[9], below_good_fall[9], lock_active} = 4'b0011;
        step(3);
        chk_alert(n);
        pulse(shutdown_n);
        onoff_uses_pin = 1'b0;
        pulse(control_active);
        rd(CMD_VENDOR_STATUS, PAGE_GLOBAL, 16'h00c0);
        chk_alert(n + 1);
        onoff_uses_pin = 1'b1;
        pulse(control_active);
        rd(CMD_VENDOR_STATUS, PAGE_GLOBAL, 16'h00c8);
        watchdog_reset_cause = 1'b1;
        rst_n = 1'b0;
        step(5);
        rst_n = 1'b1;
        step();
        watchdog_reset_cause = 1'b0;
        rd(CMD_VENDOR_STATUS, PAGE_GLOBAL, 16'h0090);
        test_done();
    end
endmodule
